// *** erc_checker.sv ***
/*
 * erc_checker: recognises a return value written to the program counter,
 * decodes it, runs the return integrity checks, and restores stack
 * selection, floating-point context flags and, on background returns, security state.
 * Assumes the stacking engine answers a started return with unstack_valid
 * or abandons it with tail_chain; all inputs are synchronous to sys_clk.
 */
`timescale 1ns/10ps
module erc_checker #(
   parameter bit HAS_SEC = 1'b1,
   parameter bit HAS_MAIN = 1'b1,
   parameter bit HAS_FP = 1'b1
) (
   input wire logic sys_clk, // core clock, 20 MHz
   input wire logic srst, // synchronous reset, active high
   input wire logic pc_write, // program counter written this cycle
   input wire logic [31:0] pc_value, // value written to the program counter
   input wire erc_pkg::erc_pc_src_t pc_src, // instruction kind behind the write
   input wire logic handler_mode, // core executes in handler mode
   input wire logic exc_active, // current exception number marked active
   input wire logic exc_entry, // pulse: exception entry taken
   input wire logic entry_to_secure, // entry target state
   input wire logic unstack_valid, // pulse: unstacked frame available
   input wire erc_pkg::erc_unstack_t unstack, // unstacked number and signature
   input wire logic tail_chain, // pulse: return abandoned for tail-chain
   input wire logic fp_clear_on_return, // clear fp registers on return
   input wire logic lazy_fp_pending, // lazy fp save pending, current bank
   input wire logic lazy_fp_pending_s, // lazy fp save pending, secure bank
   output logic ret_start, // pulse: exception return begun
   output erc_pkg::erc_fields_t ret_fields_q, // decoded fields of the return
   output logic ret_malformed_q, // captured value is malformed
   output logic ret_done, // pulse: return completed without fault
   output logic fault_valid_q, // pulse: fault raised
   output erc_pkg::erc_fault_t fault_q, // fault kind, cause and target
   output logic stack_sel_s_q, // secure control register stack selection
   output logic stack_sel_ns_q, // non-secure control register stack selection
   output logic secure_state_q, // current security state
   output logic fp_context_live_q, // fp context active flag
   output logic entry_frame_kind_q, // frame kind saved on entry
   output logic fp_zero_q, // pulse: zero S0-S15 and fp status register
   output logic fp_unstack_zero_q // pulse: zero fp registers left unstacked
);

   erc_pkg::erc_state_t state_q, state_d;
   erc_pkg::erc_fields_t dec;
   erc_pkg::erc_fault_t cap_fault, fin_fault;
   logic is_magic, start_ok, cap_has_fault, fin_has_fault;
   logic bad_info, lazy_clr_err, lazy_ns_err;
   logic exec_secure_q, bg_ret;
   logic sig_bad;

   assign is_magic = pc_value[31:erc_pkg::MAGIC_TOP_LSB] == erc_pkg::MAGIC_TOP;
   // only the listed loads start a return, and only in handler mode
   assign start_ok = pc_write && is_magic && handler_mode && state_q == erc_pkg::ST_IDLE
      && (pc_src == erc_pkg::PCW_POP_LDM || pc_src == erc_pkg::PCW_LDR
      || pc_src == erc_pkg::PCW_BX);
   assign ret_start = start_ok;

   always_comb begin
      dec.from_secure = HAS_SEC ? pc_value[erc_pkg::BIT_FROM_SEC] : 1'b0;
      dec.skip_extra_state_bit = HAS_SEC ? pc_value[erc_pkg::BIT_SKIP_EXTRA] : 1'b1;
      dec.frame_kind_bit = (HAS_MAIN && HAS_FP) ? pc_value[erc_pkg::BIT_FRAME_KIND] : 1'b1;
      dec.to_thread = pc_value[erc_pkg::BIT_MODE];
      dec.stack_choice_bit = pc_value[erc_pkg::BIT_STACK];
      dec.res0_bit = pc_value[erc_pkg::BIT_RES0];
      dec.target_secure_flag = HAS_SEC ? pc_value[erc_pkg::BIT_TGT_SEC] : 1'b0;
      // validation check: a non-secure return may not claim secure info
      bad_info = HAS_SEC && !secure_state_q && (!dec.skip_extra_state_bit || dec.target_secure_flag);
      if (bad_info) begin
         dec.target_secure_flag = 1'b0;
      end
   end

   // capture-time checks, in priority order
   always_comb begin
      lazy_clr_err = HAS_FP && fp_context_live_q && fp_clear_on_return && lazy_fp_pending;
      lazy_ns_err = HAS_FP && HAS_SEC && !dec.frame_kind_bit && lazy_fp_pending_s
         && !dec.target_secure_flag;
      cap_has_fault = 1'b1;
      cap_fault = '{kind: erc_pkg::FK_USAGE, cause: erc_pkg::FC_BAD_PC_LOAD, target_secure: secure_state_q};
      if (bad_info) begin
         cap_fault = '{kind: erc_pkg::FK_SECURE, cause: erc_pkg::FC_BAD_RETURN_INFO, target_secure: 1'b1};
      end else if (!exc_active) begin
         if (!HAS_MAIN) begin
            cap_fault = '{kind: erc_pkg::FK_HARD, cause: erc_pkg::FC_BAD_PC_LOAD,
               target_secure: dec.from_secure};
         end
      end else if (HAS_MAIN && dec.res0_bit) begin
         cap_fault.cause = erc_pkg::FC_BAD_PC_LOAD;
      end else if (lazy_clr_err || lazy_ns_err) begin
         cap_fault = '{kind: erc_pkg::FK_SECURE, cause: erc_pkg::FC_LAZY_STATE, target_secure: 1'b1};
      end else begin
         cap_has_fault = 1'b0;
      end
   end

   // unstack-time checks
   assign bg_ret = ret_fields_q.to_thread;
   always_comb begin
      if (HAS_MAIN) begin
         sig_bad = unstack.signature != {erc_pkg::SIG_MAIN_HI, ret_fields_q.frame_kind_bit};
      end else begin
         sig_bad = unstack.signature != erc_pkg::SIG_BASE;
      end
      fin_has_fault = 1'b1;
      fin_fault = '{kind: erc_pkg::FK_USAGE, cause: erc_pkg::FC_BAD_PC_LOAD, target_secure: ret_fields_q.from_secure};
      if (bg_ret != (unstack.exc_num == erc_pkg::EXC_NUM_ZERO)) begin
         if (!HAS_MAIN) begin
            fin_fault.kind = erc_pkg::FK_HARD;
         end
      end else if (HAS_SEC && ret_fields_q.from_secure && !ret_fields_q.target_secure_flag && sig_bad) begin
         fin_fault = '{kind: HAS_MAIN ? erc_pkg::FK_SECURE : erc_pkg::FK_HARD,
            cause: erc_pkg::FC_SIGNATURE, target_secure: 1'b1};
      end else begin
         fin_has_fault = 1'b0;
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         erc_pkg::ST_IDLE: begin
            if (start_ok) begin
               state_d = cap_has_fault ? erc_pkg::ST_ABORT : erc_pkg::ST_UNSTACK;
            end
         end
         erc_pkg::ST_UNSTACK: begin
            if (tail_chain) begin
               state_d = erc_pkg::ST_IDLE;
            end else if (unstack_valid) begin
               // a failed unstack check must not report completion
               state_d = fin_has_fault ? erc_pkg::ST_ABORT : erc_pkg::ST_FINISH;
            end
         end
         erc_pkg::ST_FINISH: state_d = erc_pkg::ST_IDLE;
         erc_pkg::ST_ABORT: state_d = erc_pkg::ST_IDLE;
         default: state_d = erc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_q <= erc_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   assign ret_done = state_q == erc_pkg::ST_FINISH;

   // captured return value and the state that executed the return
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ret_fields_q <= '0;
         ret_malformed_q <= 1'b0;
         exec_secure_q <= 1'b0;
      end else if (start_ok) begin
         ret_fields_q <= dec;
         exec_secure_q <= secure_state_q;
         ret_malformed_q <= (!HAS_FP && !pc_value[erc_pkg::BIT_FRAME_KIND])
            || pc_value[erc_pkg::RES1_MSB:erc_pkg::RES1_LSB] != erc_pkg::RES1_ONES
            || (!HAS_SEC && (pc_value[erc_pkg::BIT_FROM_SEC] || !pc_value[erc_pkg::BIT_SKIP_EXTRA]
            || pc_value[erc_pkg::BIT_TGT_SEC]))
            || (!HAS_MAIN && pc_value[erc_pkg::BIT_RES0]);
      end
   end

   // fault report, one cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fault_valid_q <= 1'b0;
         fault_q <= '0;
      end else begin
         fault_valid_q <= 1'b0;
         if (start_ok && cap_has_fault) begin
            fault_valid_q <= 1'b1;
            fault_q <= cap_fault;
         end else if (state_q == erc_pkg::ST_UNSTACK && unstack_valid && !tail_chain && fin_has_fault) begin
            fault_valid_q <= 1'b1;
            fault_q <= fin_fault;
         end
      end
   end

   // stack selection written once validation has run
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stack_sel_s_q <= 1'b0;
         stack_sel_ns_q <= 1'b0;
      end else if (start_ok) begin
         if (HAS_SEC && dec.target_secure_flag) begin
            stack_sel_s_q <= dec.stack_choice_bit;
         end else begin
            stack_sel_ns_q <= dec.stack_choice_bit;
         end
      end
   end

   // security state: entry target, or restored on a clean background return
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         secure_state_q <= HAS_SEC;
      end else if (exc_entry) begin
         secure_state_q <= HAS_SEC && entry_to_secure;
      end else if (state_q == erc_pkg::ST_UNSTACK && unstack_valid && !tail_chain && !fin_has_fault
         && bg_ret) begin
         secure_state_q <= ret_fields_q.from_secure;
      end
   end

   // fp context flag and frame kind bookkeeping
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fp_context_live_q <= 1'b0;
         entry_frame_kind_q <= 1'b1;
      end else if (exc_entry) begin
         entry_frame_kind_q <= !(HAS_FP && fp_context_live_q);
         fp_context_live_q <= 1'b0;
      end else if (start_ok && !cap_has_fault && HAS_FP) begin
         fp_context_live_q <= !dec.frame_kind_bit;
      end
   end

   // fp register clearing requests
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fp_zero_q <= 1'b0;
         fp_unstack_zero_q <= 1'b0;
      end else begin
         fp_zero_q <= HAS_FP && start_ok && !cap_has_fault && fp_context_live_q && fp_clear_on_return
            && !lazy_fp_pending;
         fp_unstack_zero_q <= HAS_FP && HAS_SEC && state_q == erc_pkg::ST_UNSTACK && tail_chain
            && !ret_fields_q.frame_kind_bit;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   chk_thread_no_start: assert property (!handler_mode |-> !ret_start)
      else $error("return started outside handler mode");

   chk_other_src_ignored: assert property (pc_write && (pc_src == erc_pkg::PCW_OTHER
      || pc_src == erc_pkg::PCW_VECTOR) |-> !ret_start)
      else $error("return started by a plain branch source");

   chk_start_needs_magic: assert property (ret_start |-> pc_value[31:24] == 8'hFF)
      else $error("return started without magic top byte");

   chk_start_decoded: assert property (pc_write && pc_value[31:24] == 8'hFF && handler_mode
      && pc_src == erc_pkg::PCW_BX && state_q == erc_pkg::ST_IDLE |=> ret_fields_q.stack_choice_bit
      == $past(pc_value[2]) && ret_fields_q.to_thread == $past(pc_value[3]))
      else $error("return value not captured");

   chk_bad_info_fault: assert property (ret_start && HAS_SEC && !secure_state_q && !pc_value[5]
      |=> fault_valid_q && fault_q.cause == erc_pkg::FC_BAD_RETURN_INFO && !ret_fields_q.target_secure_flag)
      else $error("bad return info not reported");

   chk_inactive_fault: assert property (ret_start && !exc_active && !bad_info |=> fault_valid_q
      && fault_q.cause == erc_pkg::FC_BAD_PC_LOAD)
      else $error("inactive exception not reported");

   chk_res0_fault: assert property (ret_start && HAS_MAIN && exc_active && pc_value[1] && !bad_info
      |=> fault_valid_q && fault_q.kind == erc_pkg::FK_USAGE)
      else $error("bit 1 set without usage fault");

   chk_mode_match: assert property (state_q == erc_pkg::ST_UNSTACK && unstack_valid && !tail_chain
      && ret_fields_q.to_thread && unstack.exc_num != 9'h000 |=> fault_valid_q && !ret_done)
      else $error("mode mismatch not reported");

   chk_stack_sel_copy: assert property (ret_start && HAS_SEC && dec.target_secure_flag
      |=> stack_sel_s_q == $past(pc_value[2]) && $stable(stack_sel_ns_q))
      else $error("secure stack selection not updated");

   chk_sec_restore: assert property (ret_done && ret_fields_q.to_thread && !$past(exc_entry)
      |-> secure_state_q == ret_fields_q.from_secure)
      else $error("security state not restored");

   chk_fp_entry: assert property (exc_entry && HAS_FP |=> !fp_context_live_q
      && entry_frame_kind_q == !$past(fp_context_live_q))
      else $error("fp flag not saved on entry");

   chk_fp_zero: assert property (ret_start && HAS_FP && fp_context_live_q && fp_clear_on_return
      && !lazy_fp_pending && !cap_has_fault |=> fp_zero_q ##1 !fp_zero_q)
      else $error("fp clear not requested");

   chk_lazy_ns: assert property (ret_start && exc_active && !bad_info && !(HAS_MAIN && pc_value[1])
      && lazy_ns_err |=> fault_valid_q && fault_q.cause == erc_pkg::FC_LAZY_STATE)
      else $error("lazy state fault missing");

   chk_tail_zero: assert property (state_q == erc_pkg::ST_UNSTACK && tail_chain && HAS_FP && HAS_SEC
      && !ret_fields_q.frame_kind_bit |=> fp_unstack_zero_q)
      else $error("unstacked fp registers not zeroed");

   chk_signature: assert property (state_q == erc_pkg::ST_UNSTACK && unstack_valid
      && !tail_chain && bg_ret == (unstack.exc_num == 9'h000) && ret_fields_q.from_secure
      && !ret_fields_q.target_secure_flag && sig_bad |=> fault_valid_q
      && fault_q.cause == erc_pkg::FC_SIGNATURE)
      else $error("signature mismatch not reported");

   chk_fp_return: assert property (ret_start && HAS_FP && HAS_MAIN && !cap_has_fault && !exc_entry
      |=> fp_context_live_q == !$past(pc_value[4]))
      else $error("fp flag not restored on return");

   chk_malformed_res1: assert property (ret_start && pc_value[23:7] != 17'h1FFFF |=> ret_malformed_q)
      else $error("reserved ones not flagged");

   chk_done_clean: assert property (fault_valid_q |-> !ret_done)
      else $error("return completed with a fault");

   chk_tail_abandon: assert property (state_q == erc_pkg::ST_UNSTACK && tail_chain
      |=> state_q == erc_pkg::ST_IDLE && !ret_done && !fault_valid_q)
      else $error("tail-chained return not abandoned");

   cov_clean_return: cover property (ret_start ##[1:20] ret_done);
   cov_fault_start: cover property (ret_start ##1 fault_valid_q);
   cov_tail_chain: cover property (state_q == erc_pkg::ST_UNSTACK && tail_chain);
   cov_sig_fault: cover property (fault_valid_q && fault_q.cause == erc_pkg::FC_SIGNATURE);

endmodule

// *** erc_pkg.sv ***
/*
 * erc_pkg: constants, enumerations and carrier structs for the exception
 * return checker.
 * Assumes a single core clock; everything here is shared by the checker and its bench.
 */
package erc_pkg;

   // return value layout
   localparam logic [7:0] MAGIC_TOP = 8'hFF;
   localparam int MAGIC_TOP_LSB = 24;
   localparam int RES1_MSB = 23;
   localparam int RES1_LSB = 7;
   localparam logic [16:0] RES1_ONES = 17'h1FFFF;
   localparam int BIT_FROM_SEC = 6;
   localparam int BIT_SKIP_EXTRA = 5;
   localparam int BIT_FRAME_KIND = 4;
   localparam int BIT_MODE = 3;
   localparam int BIT_STACK = 2;
   localparam int BIT_RES0 = 1;
   localparam int BIT_TGT_SEC = 0;

   // integrity signature, baseline core without the main extension
   localparam logic [31:0] SIG_BASE = 32'hFEFA125B;
   // main extension: upper bits fixed, bit 0 carries the frame type check
   localparam logic [30:0] SIG_MAIN_HI = 31'h7F7D092D;

   localparam logic [8:0] EXC_NUM_ZERO = 9'h000;

   // instruction that wrote the program counter
   typedef enum logic [2:0] {
      PCW_POP_LDM = 3'h0,
      PCW_LDR = 3'h1,
      PCW_BX = 3'h2,
      PCW_OTHER = 3'h3,
      PCW_VECTOR = 3'h4
   } erc_pc_src_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_UNSTACK = 4'b0010,
      ST_FINISH = 4'b0100,
      ST_ABORT = 4'b1000
   } erc_state_t;

   typedef enum logic [1:0] {
      FK_USAGE = 2'h0,
      FK_SECURE = 2'h1,
      FK_HARD = 2'h2
   } erc_fault_kind_t;

   typedef enum logic [2:0] {
      FC_BAD_RETURN_INFO = 3'h0,
      FC_BAD_PC_LOAD = 3'h1,
      FC_LAZY_STATE = 3'h2,
      FC_SIGNATURE = 3'h3
   } erc_fault_cause_t;

   typedef struct packed {
      logic from_secure;
      logic skip_extra_state_bit;
      logic frame_kind_bit;
      logic to_thread;
      logic stack_choice_bit;
      logic res0_bit;
      logic target_secure_flag;
   } erc_fields_t;

   typedef struct packed {
      erc_fault_kind_t kind;
      erc_fault_cause_t cause;
      logic target_secure;
   } erc_fault_t;

   // unstacked frame contents handed back by the stacking engine
   typedef struct packed {
      logic [8:0] exc_num;
      logic [31:0] signature;
   } erc_unstack_t;

endpackage

// *** test_exception_return_checker.sv ***
/*
 * test_exception_return_checker: directed bench for erc_checker.
 * Assumes the default parameters (security, main and fp extensions present)
 * and that the bench itself plays the core and the stacking engine.
 */
`timescale 1ns/10ps
module test_exception_return_checker;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic pc_write = 1'b0;
   logic [31:0] pc_value = 32'h00000000;
   erc_pkg::erc_pc_src_t pc_src = erc_pkg::PCW_OTHER;
   logic handler_mode = 1'b1;
   logic exc_active = 1'b1;
   logic exc_entry = 1'b0;
   logic entry_to_secure = 1'b0;
   logic unstack_valid = 1'b0;
   erc_pkg::erc_unstack_t unstack = '0;
   logic tail_chain = 1'b0;
   logic fp_clear_on_return = 1'b0;
   logic lazy_fp_pending = 1'b0;
   logic lazy_fp_pending_s = 1'b0;
   logic ret_start, ret_malformed_q, ret_done, fault_valid_q;
   erc_pkg::erc_fields_t ret_fields_q;
   erc_pkg::erc_fault_t fault_q;
   logic stack_sel_s_q, stack_sel_ns_q, secure_state_q, fp_context_live_q;
   logic entry_frame_kind_q, fp_zero_q, fp_unstack_zero_q;
   int n_fail = 0;
   int n_tests = 0;

   erc_checker dut (.sys_clk(sys_clk), .srst(srst), .pc_write(pc_write), .pc_value(pc_value), .pc_src(pc_src),
      .handler_mode(handler_mode), .exc_active(exc_active), .exc_entry(exc_entry),
      .entry_to_secure(entry_to_secure), .unstack_valid(unstack_valid), .unstack(unstack),
      .tail_chain(tail_chain), .fp_clear_on_return(fp_clear_on_return), .lazy_fp_pending(lazy_fp_pending),
      .lazy_fp_pending_s(lazy_fp_pending_s), .ret_start(ret_start), .ret_fields_q(ret_fields_q),
      .ret_malformed_q(ret_malformed_q), .ret_done(ret_done), .fault_valid_q(fault_valid_q), .fault_q(fault_q),
      .stack_sel_s_q(stack_sel_s_q), .stack_sel_ns_q(stack_sel_ns_q), .secure_state_q(secure_state_q),
      .fp_context_live_q(fp_context_live_q), .entry_frame_kind_q(entry_frame_kind_q), .fp_zero_q(fp_zero_q),
      .fp_unstack_zero_q(fp_unstack_zero_q));

   always #25 sys_clk = ~sys_clk;

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one-cycle program counter write; leaves the bench 1 ns into the next cycle
   task automatic launch(input logic [31:0] v, input erc_pkg::erc_pc_src_t s, input logic exp);
      @(posedge sys_clk);
      pc_write <= 1'b1;
      pc_value <= v;
      pc_src <= s;
      #1 chk("ret_start", {7'h00, exp}, {7'h00, ret_start});
      @(posedge sys_clk);
      pc_write <= 1'b0;
      #1;
   endtask

   // hand back the unstacked frame; leaves the bench in the completion cycle
   task automatic finish(input logic [8:0] e, input logic [31:0] sig);
      @(posedge sys_clk);
      unstack_valid <= 1'b1;
      unstack <= {e, sig};
      @(posedge sys_clk);
      unstack_valid <= 1'b0;
      #1;
   endtask

   task automatic chk_fault(input erc_pkg::erc_fault_kind_t k, input erc_pkg::erc_fault_cause_t c);
      chk("fault_valid_q", 8'h01, {7'h00, fault_valid_q});
      chk("fault kind", {6'h00, k}, {6'h00, fault_q.kind});
      chk("fault cause", {5'h00, c}, {5'h00, fault_q.cause});
   endtask

   task automatic test_reset();
      chk("secure_state_q", 8'h01, {7'h00, secure_state_q});
      chk("entry_frame_kind_q", 8'h01, {7'h00, entry_frame_kind_q});
      chk("fp_context_live_q", 8'h00, {7'h00, fp_context_live_q});
      chk("ret_fields_q", 8'h00, {1'b0, ret_fields_q});
      $display("test reset done");
   endtask

   task automatic test_ignored();
      @(posedge sys_clk);
      handler_mode <= 1'b0;
      launch(32'hFFFFFFF8, erc_pkg::PCW_BX, 1'b0);
      @(posedge sys_clk);
      handler_mode <= 1'b1;
      launch(32'hFFFFFFF8, erc_pkg::PCW_OTHER, 1'b0);
      launch(32'hFFFFFFF8, erc_pkg::PCW_VECTOR, 1'b0);
      launch(32'hFEFFFFF8, erc_pkg::PCW_BX, 1'b0);
      chk("fault_valid_q", 8'h00, {7'h00, fault_valid_q});
      chk("ret_fields_q", 8'h00, {1'b0, ret_fields_q});
      $display("test ignored done");
   endtask

   task automatic test_signature();
      launch(32'hFFFFFFF8, erc_pkg::PCW_BX, 1'b1);
      chk("ret_fields_q", 8'h78, {1'b0, ret_fields_q});
      chk("stack_sel_ns_q", 8'h00, {7'h00, stack_sel_ns_q});
      finish(9'h000, {erc_pkg::SIG_MAIN_HI, 1'b1});
      chk("ret_done", 8'h01, {7'h00, ret_done});
      chk("secure_state_q", 8'h01, {7'h00, secure_state_q});
      @(posedge sys_clk);
      launch(32'hFFFFFFF8, erc_pkg::PCW_LDR, 1'b1);
      finish(9'h000, {erc_pkg::SIG_MAIN_HI, 1'b0});
      chk_fault(erc_pkg::FK_SECURE, erc_pkg::FC_SIGNATURE);
      chk("ret_done", 8'h00, {7'h00, ret_done});
      @(posedge sys_clk);
      $display("test signature done");
   endtask

   task automatic test_clean_ns();
      launch(32'hFFFFFFAC, erc_pkg::PCW_POP_LDM, 1'b1);
      chk("ret_fields_q", 8'h2C, {1'b0, ret_fields_q});
      chk("stack_sel_ns_q", 8'h01, {7'h00, stack_sel_ns_q});
      chk("stack_sel_s_q", 8'h00, {7'h00, stack_sel_s_q});
      chk("fp_context_live_q", 8'h01, {7'h00, fp_context_live_q});
      finish(9'h000, 32'h00000000);
      chk("ret_done", 8'h01, {7'h00, ret_done});
      chk("secure_state_q", 8'h00, {7'h00, secure_state_q});
      @(posedge sys_clk);
      $display("test clean return done");
   endtask

   task automatic test_fp_clear();
      fp_clear_on_return <= 1'b1;
      lazy_fp_pending <= 1'b1;
      launch(32'hFFFFFFB8, erc_pkg::PCW_BX, 1'b1);
      chk_fault(erc_pkg::FK_SECURE, erc_pkg::FC_LAZY_STATE);
      chk("fp_zero_q", 8'h00, {7'h00, fp_zero_q});
      repeat (2) @(posedge sys_clk);
      lazy_fp_pending <= 1'b0;
      launch(32'hFFFFFFB8, erc_pkg::PCW_BX, 1'b1);
      chk("fp_zero_q", 8'h01, {7'h00, fp_zero_q});
      chk("fp_context_live_q", 8'h00, {7'h00, fp_context_live_q});
      finish(9'h000, 32'h00000000);
      chk("ret_done", 8'h01, {7'h00, ret_done});
      @(posedge sys_clk);
      fp_clear_on_return <= 1'b0;
      $display("test fp clear done");
   endtask

   // capture faults raised from non-secure state, then the return is aborted
   task automatic abort_case(input logic [31:0] v, input erc_pkg::erc_fault_kind_t k,
         input erc_pkg::erc_fault_cause_t c);
      launch(v, erc_pkg::PCW_LDR, 1'b1);
      chk_fault(k, c);
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic test_capture_faults();
      abort_case(32'hFFFFFF99, erc_pkg::FK_SECURE, erc_pkg::FC_BAD_RETURN_INFO);
      chk("target_secure_flag", 8'h00, {7'h00, ret_fields_q.target_secure_flag});
      exc_active <= 1'b0;
      abort_case(32'hFFFFFFB8, erc_pkg::FK_USAGE, erc_pkg::FC_BAD_PC_LOAD);
      chk("fault target", 8'h00, {7'h00, fault_q.target_secure});
      exc_active <= 1'b1;
      abort_case(32'hFFFFFFBA, erc_pkg::FK_USAGE, erc_pkg::FC_BAD_PC_LOAD);
      chk("fault target", 8'h00, {7'h00, fault_q.target_secure});
      lazy_fp_pending_s <= 1'b1;
      abort_case(32'hFFFFFFA8, erc_pkg::FK_SECURE, erc_pkg::FC_LAZY_STATE);
      lazy_fp_pending_s <= 1'b0;
      $display("test capture faults done");
   endtask

   task automatic test_mode_mismatch();
      launch(32'hFF7FFFB8, erc_pkg::PCW_BX, 1'b1);
      chk("ret_malformed_q", 8'h01, {7'h00, ret_malformed_q});
      finish(9'h005, 32'h00000000);
      chk_fault(erc_pkg::FK_USAGE, erc_pkg::FC_BAD_PC_LOAD);
      chk("fault target", 8'h00, {7'h00, fault_q.target_secure});
      @(posedge sys_clk);
      launch(32'hFFFFFFB0, erc_pkg::PCW_BX, 1'b1);
      chk("ret_fields_q", 8'h30, {1'b0, ret_fields_q});
      chk("ret_malformed_q", 8'h00, {7'h00, ret_malformed_q});
      finish(9'h000, 32'h00000000);
      chk_fault(erc_pkg::FK_USAGE, erc_pkg::FC_BAD_PC_LOAD);
      @(posedge sys_clk);
      $display("test mode mismatch done");
   endtask

   task automatic test_tail_entry();
      launch(32'hFFFFFFA8, erc_pkg::PCW_POP_LDM, 1'b1);
      @(posedge sys_clk);
      tail_chain <= 1'b1;
      @(posedge sys_clk);
      tail_chain <= 1'b0;
      #1 chk("fp_unstack_zero_q", 8'h01, {7'h00, fp_unstack_zero_q});
      chk("ret_done", 8'h00, {7'h00, ret_done});
      @(posedge sys_clk);
      exc_entry <= 1'b1;
      entry_to_secure <= 1'b1;
      @(posedge sys_clk);
      exc_entry <= 1'b0;
      #1 chk("entry_frame_kind_q", 8'h00, {7'h00, entry_frame_kind_q});
      chk("fp_context_live_q", 8'h00, {7'h00, fp_context_live_q});
      chk("secure_state_q", 8'h01, {7'h00, secure_state_q});
      // secure return taken to secure state: secure stack selection written
      launch(32'hFFFFFFFD, erc_pkg::PCW_BX, 1'b1);
      chk("ret_fields_q", 8'h7D, {1'b0, ret_fields_q});
      chk("stack_sel_s_q", 8'h01, {7'h00, stack_sel_s_q});
      chk("stack_sel_ns_q", 8'h00, {7'h00, stack_sel_ns_q});
      finish(9'h000, 32'h00000000);
      chk("ret_done", 8'h01, {7'h00, ret_done});
      chk("secure_state_q", 8'h01, {7'h00, secure_state_q});
      @(posedge sys_clk);
      $display("test tail chain and entry done");
   endtask

   initial begin
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      #1 test_reset();
      test_ignored();
      test_signature();
      test_clean_ns();
      test_fp_clear();
      test_capture_faults();
      test_mode_mismatch();
      test_tail_entry();
      stop_test();
   end

   // the whole sequence needs well under 200 cycles
   initial begin
      repeat (2000) @(posedge sys_clk);
      n_fail++;
      stop_test();
   end
endmodule
